//--- rtl/id_store.sv
/*
 Identifier bit store with registered read data.
 Assumes the address is stable at least one cycle before the bit is used.
*/
`timescale 1ns/10ps

module id_store #(
	parameter swl_pkg::devId_t CONTENT = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input swl_pkg::idx_t addr,
	output logic rdBit
);
	import swl_pkg::*;

	logic rdBit_q;
	logic rdBit_d;

	always_comb begin
		rdBit_d = CONTENT[addr];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdBit_q <= 1'b0;
		end else begin
			rdBit_q <= rdBit_d;
		end
	end

	assign rdBit = rdBit_q;
endmodule

//--- rtl/line_sync.sv
/*
 Two-flop synchroniser for the bus line level.
 Assumes the pin is asynchronous to clk; the line idles high.
*/
`timescale 1ns/10ps

module line_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pinIn,
	output logic level
);
	logic meta_q;
	logic level_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			meta_q <= pinIn;
			level_q <= meta_q;
		end
	end

	assign level = level_q;
endmodule

//--- rtl/swl_cfg.svh
/*
 Timing figures, command codes and sizes for the single-wire peripheral ROM layer.
 Assumes a 200 MHz core clock; all times are given in ns and converted to cycles here.
*/
`ifndef SWL_CFG_SVH
`define SWL_CFG_SVH

`define SWL_CLK_NS 5
`define SWL_CYC_UP(ns) (((ns) + `SWL_CLK_NS - 1) / `SWL_CLK_NS)
`define SWL_CYC_DN(ns) ((ns) / `SWL_CLK_NS)

// Reset recognition and overdrive retention
`define SWL_RSTL_STD_NS 480000
`define SWL_RSTL_OD_NS 48000
`define SWL_RSTL_ODKEEP_NS 80000
// Presence pulse: wait, then low
`define SWL_PWAIT_STD_NS 15000
`define SWL_PWAIT_OD_NS 2000
`define SWL_PLOW_STD_NS 60000
`define SWL_PLOW_OD_NS 8000
// Write sample point, read-zero hold, recovery
`define SWL_SAMP_STD_NS 30000
`define SWL_SAMP_OD_NS 3500
`define SWL_HOLD_STD_NS 30000
`define SWL_HOLD_OD_NS 3000
`define SWL_REC_STD_NS 5000
`define SWL_REC_OD_NS 2000

`define SWL_CNT_W 18
`define SWL_CNT_ZERO 18'h0
`define SWL_CNT_ONE 18'h1
`define SWL_CNT_MAX 18'h3ffff

`define SWL_ID_W 64
`define SWL_IDX_W 6
`define SWL_IDX_ZERO 6'h0
`define SWL_IDX_ONE 6'h1
`define SWL_IDX_LAST 6'h3f
`define SWL_CMD_LAST 6'h07

`define SWL_PH_TRUE 2'h0
`define SWL_PH_COMP 2'h1
`define SWL_PH_DIR 2'h2

`define SWL_CMD_SEARCH 8'hf0
`define SWL_CMD_READID 8'h33
`define SWL_CMD_MATCH 8'h55
`define SWL_CMD_SKIP 8'hcc
`define SWL_CMD_RESUME 8'ha5
`define SWL_CMD_ODSKIP 8'h3c
`define SWL_CMD_ODMATCH 8'h69

`endif

//--- rtl/swl_pkg.sv
/*
 Types shared by the single-wire peripheral ROM layer.
 Assumes swl_cfg.svh is reachable on the include path.
*/
`include "swl_cfg.svh"

package swl_pkg;

	typedef logic [`SWL_CNT_W-1:0] cnt_t;
	typedef logic [`SWL_IDX_W-1:0] idx_t;
	typedef logic [`SWL_ID_W-1:0] devId_t;

	typedef enum logic [2:0] {LN_IDLE, LN_LOW, LN_REC, LN_PWAIT, LN_PLOW, LN_PEND} lineState_t;

	typedef enum logic [2:0] {RS_IDLE, RS_CMD, RS_READID, RS_MATCH, RS_SEARCH, RS_FUNC} romState_t;

	// Hand-off to the function-command layer
	typedef struct packed {
		logic active;
		logic rxValid;
		logic rxBit;
	} fnBus_t;

endpackage

//--- rtl/swl_rom_layer.sv
/*
 Peripheral side of an open-drain single-wire bus: reset/presence, bit slots at
 standard and overdrive speed, and the ROM command layer up to function hand-off.
 Assumes an external pull-up, a single bus controller, and line_sync/id_store.
*/
// Summary of operation
// - Controller makes falls; we only start presence
// - Standard speed unless overdrive flag set
// - Reset of 480us or more clears overdrive
// - Overdrive reset up to 80us keeps overdrive
// - Overdrive reset 80-480us resets, speed undefined
// - After reset release, wait then presence low
// - Accept slots right after reset high time
// - Slot fall starts timer for sample/drive
// - Recovery time needed before next slot
// - Read zero: pull low until timer; one: release
// - One 8-bit ROM command after presence
// - Decode search, identifier read, identifier match
// - Decode skip-addressing and resume
// - Decode overdrive skip and overdrive match
// - Search: true bit, complement, controller direction
// - Search mismatch stops driving remaining slots
// - Identifier read sends family, serial, CRC
// - Match 64 bits; mismatch idles until reset
// - Skip goes straight to function commands
// - Resume flag set by success, cleared by skip or failure
// - Overdrive skip sets overdrive, acts as skip
// - Overdrive match selects only on exact match
`timescale 1ns/10ps
`include "swl_cfg.svh"

module swl_rom_layer #(
	parameter swl_pkg::devId_t DEVICE_ID = 64'h5a3c_0f96_e1d2_7b48, // arbitrary value
	parameter swl_pkg::cnt_t RSTL_STD_CYC = swl_pkg::cnt_t'(`SWL_CYC_UP(`SWL_RSTL_STD_NS)),
	parameter swl_pkg::cnt_t RSTL_OD_CYC = swl_pkg::cnt_t'(`SWL_CYC_UP(`SWL_RSTL_OD_NS)),
	parameter swl_pkg::cnt_t ODKEEP_CYC = swl_pkg::cnt_t'(`SWL_CYC_DN(`SWL_RSTL_ODKEEP_NS)),
	parameter swl_pkg::cnt_t PLOW_STD_CYC = swl_pkg::cnt_t'(`SWL_CYC_UP(`SWL_PLOW_STD_NS)),
	parameter swl_pkg::cnt_t SAMP_STD_CYC = swl_pkg::cnt_t'(`SWL_CYC_UP(`SWL_SAMP_STD_NS)),
	parameter swl_pkg::cnt_t HOLD_STD_CYC = swl_pkg::cnt_t'(`SWL_CYC_UP(`SWL_HOLD_STD_NS))
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic dqIn,
	output logic dqOut,
	output logic dqOe,
	output logic overdrive,
	output swl_pkg::fnBus_t fn
);
	import swl_pkg::*;

	localparam cnt_t PWAIT_STD_CYC = cnt_t'(`SWL_CYC_UP(`SWL_PWAIT_STD_NS));
	localparam cnt_t PWAIT_OD_CYC = cnt_t'(`SWL_CYC_UP(`SWL_PWAIT_OD_NS));
	localparam cnt_t PLOW_OD_CYC = cnt_t'(`SWL_CYC_UP(`SWL_PLOW_OD_NS));
	localparam cnt_t SAMP_OD_CYC = cnt_t'(`SWL_CYC_UP(`SWL_SAMP_OD_NS));
	localparam cnt_t HOLD_OD_CYC = cnt_t'(`SWL_CYC_UP(`SWL_HOLD_OD_NS));
	localparam cnt_t REC_STD_CYC = cnt_t'(`SWL_CYC_UP(`SWL_REC_STD_NS));
	localparam cnt_t REC_OD_CYC = cnt_t'(`SWL_CYC_UP(`SWL_REC_OD_NS));

	function automatic cnt_t speedSel(input logic fast, input cnt_t stdCyc, input cnt_t odCyc);
		speedSel = fast ? odCyc : stdCyc;
	endfunction

	logic lineLevel;
	logic lineLow;
	logic idBit;
	logic txEn;
	logic txBit;
	logic bitDone;
	logic rxBit;
	logic rstEvt;
	logic rstLong;
	logic cmdDone;
	logic [7:0] cmdCode;
	cnt_t rstCyc, pwaitCyc, plowCyc, sampCyc, holdCyc, recCyc;

	lineState_t lnSt_q, lnSt_d;
	cnt_t cnt_q, cnt_d;
	logic dqOe_q, dqOe_d;
	logic rstSeen_q, rstSeen_d;

	romState_t romSt_q, romSt_d;
	idx_t bitIdx_q, bitIdx_d;
	logic [1:0] phase_q, phase_d;
	logic [7:0] shift_q, shift_d;
	logic match_q, match_d;
	logic odMatch_q, odMatch_d;
	logic odPrev_q, odPrev_d;
	logic od_q, od_d;
	logic resume_q, resume_d;
	fnBus_t fn_q, fn_d;

	line_sync uSync (
		.clk(clk),
		.rstn(rstn),
		.pinIn(dqIn),
		.level(lineLevel)
	);

	id_store #(.CONTENT(DEVICE_ID)) uId (
		.clk(clk),
		.rstn(rstn),
		.addr(bitIdx_q),
		.rdBit(idBit)
	);

	assign lineLow = !lineLevel;

	always_comb begin
		rstCyc = speedSel(od_q, RSTL_STD_CYC, RSTL_OD_CYC);
		pwaitCyc = speedSel(od_q, PWAIT_STD_CYC, PWAIT_OD_CYC);
		plowCyc = speedSel(od_q, PLOW_STD_CYC, PLOW_OD_CYC);
		sampCyc = speedSel(od_q, SAMP_STD_CYC, SAMP_OD_CYC);
		holdCyc = speedSel(od_q, HOLD_STD_CYC, HOLD_OD_CYC);
		recCyc = speedSel(od_q, REC_STD_CYC, REC_OD_CYC);
	end

	assign txEn = (romSt_q == RS_READID) || (romSt_q == RS_SEARCH && phase_q != `SWL_PH_DIR);
	assign txBit = (romSt_q == RS_SEARCH && phase_q == `SWL_PH_COMP) ? !idBit : idBit;
	assign rxBit = !lineLow;
	assign rstLong = rstSeen_q && (cnt_q > ODKEEP_CYC);

	always_comb begin
		lnSt_d = lnSt_q;
		cnt_d = (cnt_q == `SWL_CNT_MAX) ? cnt_q : cnt_q + `SWL_CNT_ONE;
		dqOe_d = dqOe_q;
		rstSeen_d = rstSeen_q;
		bitDone = 1'b0;
		rstEvt = 1'b0;
		case (lnSt_q)
			LN_IDLE: begin
				cnt_d = `SWL_CNT_ZERO;
				if (lineLow) begin
					lnSt_d = LN_LOW;
					rstSeen_d = 1'b0;
					dqOe_d = txEn && !txBit;
				end
			end
			LN_LOW: begin
				if (cnt_q == sampCyc) begin
					bitDone = 1'b1;
				end
				if (dqOe_q && cnt_q == holdCyc) begin
					dqOe_d = 1'b0;
				end
				if (cnt_q == rstCyc) begin
					rstSeen_d = 1'b1;
				end
				if (!lineLow && !dqOe_q && cnt_q > sampCyc) begin
					cnt_d = `SWL_CNT_ZERO;
					if (rstSeen_q) begin
						lnSt_d = LN_PWAIT;
						rstEvt = 1'b1;
					end else begin
						lnSt_d = LN_REC;
					end
				end
			end
			LN_REC: begin
				if (cnt_q == recCyc) begin
					lnSt_d = LN_IDLE;
				end
			end
			LN_PWAIT: begin
				if (lineLow) begin
					lnSt_d = LN_LOW;
					cnt_d = `SWL_CNT_ZERO;
					rstSeen_d = 1'b0;
				end else if (cnt_q == pwaitCyc) begin
					lnSt_d = LN_PLOW;
					cnt_d = `SWL_CNT_ZERO;
					dqOe_d = 1'b1;
				end
			end
			LN_PLOW: begin
				if (cnt_q == plowCyc) begin
					lnSt_d = LN_PEND;
					dqOe_d = 1'b0;
				end
			end
			LN_PEND: begin
				if (!lineLow) begin
					lnSt_d = LN_IDLE;
				end
			end
			default: begin
				lnSt_d = LN_IDLE;
				dqOe_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lnSt_q <= LN_IDLE;
			cnt_q <= `SWL_CNT_ZERO;
			dqOe_q <= 1'b0;
			rstSeen_q <= 1'b0;
		end else begin
			lnSt_q <= lnSt_d;
			cnt_q <= cnt_d;
			dqOe_q <= dqOe_d;
			rstSeen_q <= rstSeen_d;
		end
	end

	assign cmdCode = {rxBit, shift_q[7:1]};
	assign cmdDone = bitDone && romSt_q == RS_CMD && bitIdx_q == `SWL_CMD_LAST;

	always_comb begin
		romSt_d = romSt_q;
		bitIdx_d = bitIdx_q;
		phase_d = phase_q;
		shift_d = shift_q;
		match_d = match_q;
		odMatch_d = odMatch_q;
		odPrev_d = odPrev_q;
		od_d = od_q;
		resume_d = resume_q;
		fn_d = '0;
		fn_d.active = romSt_q == RS_FUNC;
		if (rstEvt) begin
			romSt_d = RS_CMD;
			bitIdx_d = `SWL_IDX_ZERO;
			phase_d = `SWL_PH_TRUE;
			fn_d.active = 1'b0;
			if (rstLong) begin
				od_d = 1'b0;
			end
		end else if (bitDone) begin
			case (romSt_q)
				RS_CMD: begin
					shift_d = cmdCode;
					bitIdx_d = bitIdx_q + `SWL_IDX_ONE;
					if (cmdDone) begin
						bitIdx_d = `SWL_IDX_ZERO;
						match_d = 1'b1;
						odMatch_d = 1'b0;
						case (cmdCode)
							`SWL_CMD_SEARCH: romSt_d = RS_SEARCH;
							`SWL_CMD_READID: romSt_d = RS_READID;
							`SWL_CMD_MATCH: romSt_d = RS_MATCH;
							`SWL_CMD_SKIP: begin
								romSt_d = RS_FUNC;
								resume_d = 1'b0;
							end
							`SWL_CMD_RESUME: romSt_d = resume_q ? RS_FUNC : RS_IDLE;
							`SWL_CMD_ODSKIP: begin
								od_d = 1'b1;
								romSt_d = RS_FUNC;
								resume_d = 1'b0;
							end
							`SWL_CMD_ODMATCH: begin
								odPrev_d = od_q;
								od_d = 1'b1;
								odMatch_d = 1'b1;
								romSt_d = RS_MATCH;
							end
							default: romSt_d = RS_IDLE;
						endcase
					end
				end
				RS_READID: begin
					bitIdx_d = bitIdx_q + `SWL_IDX_ONE;
					if (bitIdx_q == `SWL_IDX_LAST) begin
						romSt_d = RS_FUNC;
					end
				end
				RS_MATCH: begin
					bitIdx_d = bitIdx_q + `SWL_IDX_ONE;
					match_d = match_q && (rxBit == idBit);
					if (bitIdx_q == `SWL_IDX_LAST) begin
						romSt_d = match_d ? RS_FUNC : RS_IDLE;
						resume_d = match_d;
						if (odMatch_q && !match_d) begin
							od_d = odPrev_q;
						end
					end
				end
				RS_SEARCH: begin
					phase_d = phase_q + 2'h1;
					if (phase_q == `SWL_PH_DIR) begin
						phase_d = `SWL_PH_TRUE;
						bitIdx_d = bitIdx_q + `SWL_IDX_ONE;
						if (rxBit != idBit) begin
							romSt_d = RS_IDLE;
							resume_d = 1'b0;
						end else if (bitIdx_q == `SWL_IDX_LAST) begin
							romSt_d = RS_FUNC;
							resume_d = 1'b1;
						end
					end
				end
				RS_FUNC: begin
					fn_d.rxValid = 1'b1;
					fn_d.rxBit = rxBit;
				end
				default: romSt_d = romSt_q;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			romSt_q <= RS_IDLE;
			bitIdx_q <= `SWL_IDX_ZERO;
			phase_q <= `SWL_PH_TRUE;
			shift_q <= 8'h00;
			match_q <= 1'b0;
			odMatch_q <= 1'b0;
			odPrev_q <= 1'b0;
			od_q <= 1'b0;
			resume_q <= 1'b0;
			fn_q <= '0;
		end else begin
			romSt_q <= romSt_d;
			bitIdx_q <= bitIdx_d;
			phase_q <= phase_d;
			shift_q <= shift_d;
			match_q <= match_d;
			odMatch_q <= odMatch_d;
			odPrev_q <= odPrev_d;
			od_q <= od_d;
			resume_q <= resume_d;
			fn_q <= fn_d;
		end
	end

	// Open drain: only the enable ever changes
	assign dqOut = 1'b0;
	assign dqOe = dqOe_q;
	assign overdrive = od_q;
	assign fn = fn_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence sPresWaitEnd;
		lnSt_q == LN_PWAIT && !lineLow && cnt_q == pwaitCyc;
	endsequence

	sequence sPresDrive;
		dqOe_q && lnSt_q == LN_PLOW;
	endsequence

	sequence sReadOneFall;
		lnSt_q == LN_IDLE && lineLow && txEn && txBit;
	endsequence

	AST_DRIVE_ONLY_SLOT_OR_PRES: assert property (dqOe_q |-> (lnSt_q == LN_LOW || lnSt_q == LN_PLOW))
		else $error("line driven outside a slot or presence");
	AST_OD_LONG_RESET: assert property (rstEvt && rstLong |=> !od_q)
		else $error("long reset left overdrive set");
	AST_OD_SHORT_KEEP: assert property (rstEvt && od_q && !rstLong |=> od_q && romSt_q == RS_CMD)
		else $error("short overdrive reset lost overdrive");
	AST_PRESENCE: assert property (sPresWaitEnd |=> sPresDrive ##1 dqOe_q)
		else $error("presence pulse not started");
	AST_SAMPLE_POINT: assert property (bitDone |-> lnSt_q == LN_LOW && cnt_q == sampCyc)
		else $error("bit sampled off the timer point");
	AST_READ_RELEASE: assert property (dqOe_q && lnSt_q == LN_LOW && cnt_q == holdCyc |=> !dqOe_q)
		else $error("read zero not released at timer end");
	AST_READ_ONE: assert property (sReadOneFall |=> !dqOe_q [*2])
		else $error("line driven for a read one");
	AST_SKIP: assert property (cmdDone && cmdCode == `SWL_CMD_SKIP |=> romSt_q == RS_FUNC && !resume_q)
		else $error("skip did not reach function layer");
	AST_ODSKIP: assert property (cmdDone && cmdCode == `SWL_CMD_ODSKIP |=> od_q && romSt_q == RS_FUNC)
		else $error("overdrive skip did not set overdrive");
	AST_SEARCH_DROP: assert property (bitDone && romSt_q == RS_SEARCH && phase_q == `SWL_PH_DIR
		&& rxBit != idBit |=> romSt_q == RS_IDLE)
		else $error("search kept going after mismatch");
	AST_RESUME_GATE: assert property (cmdDone && cmdCode == `SWL_CMD_RESUME && !resume_q
		|=> romSt_q == RS_IDLE)
		else $error("resume accepted without flag");
endmodule

//--- tb/bus_ctl_model.sv
/*
 Bus controller model: drives the single wire through an open-drain pull-down.
 Assumes a pull-up on the line, the bench's speed choice on fast, shortened design timing.
*/
`timescale 1ns/10ps

module bus_ctl_model (
	input wire logic clk,
	input wire logic fast,
	input wire logic dqOe,
	output logic dqIn
);
	logic pullLow = 1'h0;

	assign dqIn = ~(pullLow | dqOe);

	task automatic lowFor(input int n);
		@(posedge clk) pullLow <= 1'h1;
		repeat (n) @(posedge clk);
		pullLow <= 1'h0;
	endtask

	task automatic busReset(input int lowCyc, output logic pres);
		lowFor(lowCyc);
		repeat (fast ? 1000 : 3100) @(posedge clk);
		pres = dqIn;
		repeat (fast ? 1100 : 150) @(posedge clk);
	endtask

	task automatic writeBit(input logic b);
		lowFor(b ? 5 : (fast ? 720 : 120));
		repeat (b ? (fast ? 1125 : 1105) : (fast ? 410 : 1010)) @(posedge clk);
	endtask

	// short low, sample in window, wait slot
	task automatic readBit(output logic b);
		lowFor(5);
		repeat (fast ? 300 : 60) @(posedge clk);
		b = dqIn;
		repeat (fast ? 825 : 1045) @(posedge clk);
	endtask

	// one command byte, low bit first
	task automatic sendByte(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			writeBit(v[i]);
	endtask
endmodule

//--- tb/single_wire_peripheral_rom_layer_tb.sv
/*
 Self-checking bench for swl_rom_layer: bus reset, commands, slots and overdrive.
 Assumes bus_ctl_model as controller; long counts are shortened by parameters.
*/
`timescale 1ns/10ps

module single_wire_peripheral_rom_layer_tb;
	import swl_pkg::*;
	localparam devId_t ID = 64'h0123_4567_89ab_cd5e; // arbitrary value
	// Shortened thresholds; od write-zero low must stay below the od reset count
	localparam cnt_t RSTL_STD = 18'h30c;
	localparam cnt_t RSTL_OD = 18'h2e4;
	localparam cnt_t ODKEEP = 18'h2f8;
	localparam cnt_t PLOW_STD = 18'hc8;
	localparam cnt_t SAMP_STD = 18'h64;
	localparam cnt_t HOLD_STD = 18'h64;
	localparam int STD_RST_LOW = 800;
	localparam int OD_KEEP_LOW = 750;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic fast = 1'h0;
	logic dqIn;
	logic dqOut;
	logic dqOe;
	logic overdrive;
	fnBus_t fn;
	int bad_count = 0;
	int n_compared = 0;
	int rxCount = 0;
	logic [7:0] rxBits = 8'h0;
	logic pres;

	always #2.5 clk = ~clk;

	swl_rom_layer #(
		.DEVICE_ID(ID),
		.RSTL_STD_CYC(RSTL_STD),
		.RSTL_OD_CYC(RSTL_OD),
		.ODKEEP_CYC(ODKEEP),
		.PLOW_STD_CYC(PLOW_STD),
		.SAMP_STD_CYC(SAMP_STD),
		.HOLD_STD_CYC(HOLD_STD)
	) uut (
		.clk(clk),
		.rstn(rstn),
		.dqIn(dqIn),
		.dqOut(dqOut),
		.dqOe(dqOe),
		.overdrive(overdrive),
		.fn(fn)
	);

	bus_ctl_model ctl (.clk(clk), .fast(fast), .dqOe(dqOe), .dqIn(dqIn));

	always @(posedge clk) begin
		if (fn.rxValid === 1'h1) begin
			rxCount <= rxCount + 1;
			rxBits <= {rxBits[6:0], fn.rxBit};
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic test_skip;
		ctl.busReset(STD_RST_LOW, pres);
		check(pres, 1'h0, "presence std");
		ctl.sendByte(8'hcc);
		check(fn.active, 1'h1, "skip active");
		check(overdrive, 1'h0, "std speed");
		ctl.writeBit(1'h0);
		ctl.writeBit(1'h1);
		check(8'(rxCount), 8'h2, "data slots");
		check(rxBits[1:0], 2'h1, "data bits");
	endtask

	// Skip left the flag clear, so resume must stay idle
	task automatic test_resume;
		ctl.busReset(STD_RST_LOW, pres);
		check(fn.active, 1'h0, "idle after reset");
		ctl.sendByte(8'ha5);
		check(fn.active, 1'h0, "resume refused");
	endtask

	task automatic test_readid;
		logic [7:0] fam;
		ctl.busReset(STD_RST_LOW, pres);
		ctl.sendByte(8'h33);
		for (int i = 0; i < 8; i++)
			ctl.readBit(fam[i]);
		check(fam, ID[7:0], "family code");
	endtask

	// Match bit 0, then choose against bit 1
	task automatic test_search;
		logic [5:0] r;
		ctl.busReset(STD_RST_LOW, pres);
		ctl.sendByte(8'hf0);
		ctl.readBit(r[0]);
		ctl.readBit(r[1]);
		ctl.writeBit(ID[0]);
		ctl.readBit(r[2]);
		ctl.readBit(r[3]);
		ctl.writeBit(~ID[1]);
		ctl.readBit(r[4]);
		ctl.readBit(r[5]);
		check(r[3:0], {~ID[1], ID[1], ~ID[0], ID[0]}, "triplets");
		check(r[5:4], 2'h3, "dropped out");
	endtask

	task automatic test_overdrive;
		ctl.busReset(STD_RST_LOW, pres);
		ctl.sendByte(8'h3c);
		check(overdrive, 1'h1, "od skip");
		check(fn.active, 1'h1, "od skip active");
		fast = 1'h1;
		ctl.busReset(OD_KEEP_LOW, pres);
		check(pres, 1'h0, "presence od");
		check(overdrive, 1'h1, "short reset keeps od");
		ctl.sendByte(8'hcc);
		check(fn.active, 1'h1, "skip at od");
		fast = 1'h0;
		ctl.busReset(STD_RST_LOW, pres);
		check(overdrive, 1'h0, "long reset clears od");
		check(pres, 1'h0, "presence back at std");
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		repeat (4) @(posedge clk);
		check(dqOe, 1'h0, "no pull after reset");
		check(dqOut, 1'h0, "open drain data");
		test_skip();
		test_resume();
		test_readid();
		test_search();
		test_overdrive();
		tally_and_finish();
	end

	// Scenarios need about 101k cycles
	initial begin
		repeat (104000) @(posedge clk);
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
